/* src/hsd_core.sv */
/*
  hsd_core: signal path and configuration store of the programmable magnetic switch.
  field sample filter, gain with temperature shaping, zero-field offset, hysteresis
  comparator, configuration registers with permanent freeze, selection and command port.
  assumes the supply monitor and the telegram codec sit
  outside and present synchronous levels and one-cycle command strobes.
*/
// Summary of operation
// - output goes low above high threshold, high below low threshold.
// - gain is signed -4..4 in 1/2048 steps; gain 1 gives span per 2048.
// - zero-field offset, -span..span in two-step units, is added to scaled sample.
// - negative offset clamps signal maximum to offset plus one span.
// - mode low three bits select converter field range, sent to front end.
// - mode high three bits select low-pass cut-off.
// - field sample is signed, positive for north pole on branded side.
// - sample is low-pass filtered and made readable before gain and offset.
// - filtered sample is limited per cut-off setting.
// - normal supply switches; raised supply, unless frozen, decodes commands, no switching.
// - only a device selected by a pulse on its output takes part.
// - configuration programmable until frozen; freeze bit clears only at a reset with stored freeze low.
// - factory trim is read-only to the customer.
// - linear and quadratic temperature coefficients shape the gain.
// - signal is gain times sample plus offset from stored configuration.
// - low threshold spans half supply, high threshold full supply, 2.44 mV steps.
// - freeze bit is one bit; once set every modulation and command is ignored.
// - readout is the 14-bit filtered sample, readable by the programmer.
`timescale 1ns/1ps
`default_nettype none
module hsd_core
  import hsd_pkg::*;
#(
  parameter logic [DATA_W-1:0] TRIM_VALUE = 16'h0000, // arbitrary factory trim image
  parameter int IDX_W = 4
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // converter and temperature
  input wire logic i_sample_valid,
  input wire logic signed [SAMPLE_W-1:0] i_sample,
  input wire logic signed [TC_W-1:0] i_temp_delta,
  output logic [SEL_W-1:0] o_field_range,
  // supply monitor and nonvolatile freeze state
  input wire logic i_raised_supply,
  input wire logic i_stored_freeze,
  // output pin
  input wire logic i_out_pin,
  output logic o_out,
  output logic o_out_oe,
  // decoded command port
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic [IDX_W-1:0] i_cmd_index,
  input wire logic [DATA_W-1:0] i_cmd_wdata,
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_data,
  output logic o_selected
);
  initial if (IDX_W != 4) $error("hsd_core: IDX_W must be 4");

  logic [MODE_W-1:0] mode_q, mode_d;
  logic signed [TC_W-1:0] lin_tc_q, lin_tc_d, quad_tc_q, quad_tc_d;
  logic signed [GAIN_W-1:0] gain_q, gain_d;
  logic signed [OFS_W-1:0] zero_field_offset_q, zero_field_offset_d;
  logic [LOW_W-1:0] low_q, low_d;
  logic [HIGH_W-1:0] high_q, high_d;
  logic permanent_freeze_bit_q, permanent_freeze_bit_d;
  logic sel_q, sel_d, pin_q;
  logic rsp_valid_q, rsp_valid_d;
  logic [DATA_W-1:0] rsp_data_q, rsp_data_d;
  logic [SIG_W-1:0] sig_q, sig_d;
  logic out_q, out_d;
  logic signed [SAMPLE_W-1:0] filtered;
  logic prog_active, cmd_ok, wr;
  logic signed [39:0] tcorr, gain_eff, scaled, sig_w, sig_max;

  // filter ahead of gain, offset and comparison
  hsd_lowpass #(.W(SAMPLE_W)) u_lowpass (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_sample_valid(i_sample_valid),
    .i_sample(i_sample),
    .i_cutoff(mode_q[CUTOFF_LSB +: SEL_W]),
    .o_filtered(filtered)
  );

  assign o_field_range = mode_q[RANGE_LSB +: SEL_W];

  // programming session: raised supply, unless frozen
  always_comb begin
    prog_active = i_raised_supply && !permanent_freeze_bit_q;
    cmd_ok = prog_active && sel_q && i_cmd_valid;
    wr = cmd_ok && i_cmd_write && !permanent_freeze_bit_q;
    sel_d = sel_q;
    if (!prog_active) begin
      sel_d = 1'b0;
    end else if (i_out_pin && !pin_q) begin
      sel_d = 1'b1;
    end
  end

  // configuration store
  always_comb begin
    mode_d = mode_q;
    lin_tc_d = lin_tc_q;
    quad_tc_d = quad_tc_q;
    gain_d = gain_q;
    zero_field_offset_d = zero_field_offset_q;
    low_d = low_q;
    high_d = high_q;
    permanent_freeze_bit_d = permanent_freeze_bit_q;
    if (wr) begin
      unique case (i_cmd_index)
        IDX_RANGE_CUTOFF: mode_d = i_cmd_wdata[MODE_W-1:0];
        IDX_LIN_TC: lin_tc_d = i_cmd_wdata[TC_W-1:0];
        IDX_QUAD_TC: quad_tc_d = i_cmd_wdata[TC_W-1:0];
        IDX_GAIN: gain_d = i_cmd_wdata[GAIN_W-1:0];
        IDX_ZERO_OFS: zero_field_offset_d = i_cmd_wdata[OFS_W-1:0];
        IDX_LOW_THR: low_d = i_cmd_wdata[LOW_W-1:0];
        IDX_HIGH_THR: high_d = i_cmd_wdata[HIGH_W-1:0];
        IDX_FREEZE: permanent_freeze_bit_d = permanent_freeze_bit_q | i_cmd_wdata[0];
        default: ; // trim and readout ignore writes
      endcase
    end
  end

  // read answer, one cycle after the command
  always_comb begin
    rsp_valid_d = cmd_ok && !i_cmd_write;
    rsp_data_d = rsp_data_q;
    if (cmd_ok && !i_cmd_write) begin
      unique case (i_cmd_index)
        IDX_RANGE_CUTOFF: rsp_data_d = DATA_W'(mode_q);
        IDX_LIN_TC: rsp_data_d = DATA_W'(lin_tc_q);
        IDX_QUAD_TC: rsp_data_d = DATA_W'(quad_tc_q);
        IDX_GAIN: rsp_data_d = DATA_W'(gain_q);
        IDX_ZERO_OFS: rsp_data_d = DATA_W'(zero_field_offset_q);
        IDX_LOW_THR: rsp_data_d = DATA_W'(low_q);
        IDX_HIGH_THR: rsp_data_d = DATA_W'(high_q);
        IDX_FREEZE: rsp_data_d = DATA_W'(permanent_freeze_bit_q);
        IDX_TRIM: rsp_data_d = TRIM_VALUE;
        IDX_READOUT: rsp_data_d = DATA_W'($signed(filtered));
        default: rsp_data_d = 16'h0000;
      endcase
    end
  end

  // gain with temperature shaping, offset and clamp
  always_comb begin
    tcorr = 40'(lin_tc_q) * 40'(i_temp_delta) * 40'(LIN_TC_SCALE)
          + 40'(quad_tc_q) * 40'(i_temp_delta) * 40'(i_temp_delta);
    gain_eff = 40'(gain_q) + ((40'(gain_q) * tcorr) >>> TEMP_FRAC);
    scaled = (gain_eff * 40'(filtered)) >>> GAIN_FRAC;
    sig_w = scaled + (40'(zero_field_offset_q) <<< 1);
    sig_max = (zero_field_offset_q < 0) ? (40'(zero_field_offset_q) <<< 1) + SPAN : SPAN;
    if (sig_w > sig_max) begin
      sig_d = SIG_W'(sig_max);
    end else if (sig_w < 0) begin
      sig_d = '0;
    end else begin
      sig_d = SIG_W'(sig_w);
    end
  end

  // hysteresis comparator, frozen during a programming session
  always_comb begin
    out_d = out_q;
    if (!prog_active) begin
      if (sig_q > SIG_W'(high_q)) begin
        out_d = 1'b0;
      end else if (sig_q < SIG_W'(low_q)) begin
        out_d = 1'b1;
      end
    end
  end

  // configuration store registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mode_q <= MODE_RST;
      lin_tc_q <= TC_RST;
      quad_tc_q <= TC_RST;
      gain_q <= GAIN_RST;
      zero_field_offset_q <= OFS_RST;
      low_q <= LOW_RST;
      high_q <= HIGH_RST;
      permanent_freeze_bit_q <= i_stored_freeze;
    end else begin
      mode_q <= mode_d;
      lin_tc_q <= lin_tc_d;
      quad_tc_q <= quad_tc_d;
      gain_q <= gain_d;
      zero_field_offset_q <= zero_field_offset_d;
      low_q <= low_d;
      high_q <= high_d;
      permanent_freeze_bit_q <= permanent_freeze_bit_d | i_stored_freeze;
    end
  end

  // session registers; pin history starts at the driven-high idle level
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sel_q <= 1'b0;
      pin_q <= 1'b1;
    end else begin
      sel_q <= sel_d;
      pin_q <= i_out_pin;
    end
  end

  // read answer registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // signal path registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sig_q <= '0;
      out_q <= 1'b1;
    end else begin
      sig_q <= sig_d;
      out_q <= out_d;
    end
  end

  assign o_out = out_q;
  assign o_out_oe = !prog_active;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_data = rsp_data_q;
  assign o_selected = sel_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_read_taken;
    cmd_ok && !i_cmd_write;
  endsequence
  sequence s_write_frozen;
    i_cmd_valid && i_cmd_write && permanent_freeze_bit_q;
  endsequence
  sequence s_select_edge;
    prog_active && i_out_pin && !pin_q;
  endsequence

  a_switch_low_above: assert property (
    !prog_active && sig_q > SIG_W'(high_q) |=> !o_out)
    else $error("output not low above high threshold");
  a_switch_high_below: assert property (
    !prog_active && sig_q < SIG_W'(low_q) && sig_q <= SIG_W'(high_q) |=> o_out)
    else $error("output not high below low threshold");
  a_hold_between: assert property (
    sig_q >= SIG_W'(low_q) && sig_q <= SIG_W'(high_q) |=> $stable(o_out))
    else $error("output moved inside hysteresis band");
  a_freeze_sticky: assert property (
    permanent_freeze_bit_q |=> permanent_freeze_bit_q [*8])
    else $error("freeze bit cleared");
  a_frozen_no_write: assert property (
    s_write_frozen |=> $stable(gain_q) && $stable(mode_q) && $stable(high_q))
    else $error("configuration changed while frozen");
  a_read_answer: assert property (
    s_read_taken |=> o_rsp_valid)
    else $error("read answer not one cycle after command");
  a_no_stray_answer: assert property (
    !(cmd_ok && !i_cmd_write) |=> !o_rsp_valid)
    else $error("answer without a taken read");
  a_unselected_mute: assert property (
    !sel_q |=> !o_rsp_valid)
    else $error("unselected device answered");
  a_signal_clamp: assert property (
    zero_field_offset_q < 0
      |=> 40'(sig_q) <= (40'($past(zero_field_offset_q)) <<< 1) + SPAN)
    else $error("signal above negative offset clamp");
  a_pin_released: assert property (
    i_raised_supply && !permanent_freeze_bit_q |-> !o_out_oe ##1 $stable(o_out) || !prog_active)
    else $error("pin driven or switching during programming");
  a_select_edge: assert property (
    s_select_edge |=> sel_q)
    else $error("select pulse not taken");
  a_select_drop: assert property (
    !prog_active |=> !sel_q)
    else $error("selection kept outside a session");
  a_trim_answer: assert property (
    cmd_ok && !i_cmd_write && i_cmd_index == IDX_TRIM |=> o_rsp_data == TRIM_VALUE)
    else $error("trim read answer wrong");
  a_readout_answer: assert property (
    cmd_ok && !i_cmd_write && i_cmd_index == IDX_READOUT |=> o_rsp_data == DATA_W'($past(filtered)))
    else $error("readout answer is not the filtered sample");
  a_unmapped_zero: assert property (
    cmd_ok && !i_cmd_write && i_cmd_index > IDX_READOUT |=> o_rsp_data == 16'h0000)
    else $error("unmapped read not zero");
  a_mode_written: assert property (
    wr && i_cmd_index == IDX_RANGE_CUTOFF |=> mode_q == MODE_W'($past(i_cmd_wdata)))
    else $error("mode write not stored");
  a_gain_written: assert property (
    wr && i_cmd_index == IDX_GAIN |=> gain_q == GAIN_W'($past(i_cmd_wdata)))
    else $error("gain write not stored");
  a_freeze_set: assert property (
    wr && i_cmd_index == IDX_FREEZE && i_cmd_wdata[0] |=> permanent_freeze_bit_q)
    else $error("freeze write not taken");
  a_stored_freeze: assert property (
    i_stored_freeze |=> permanent_freeze_bit_q)
    else $error("stored freeze not applied");
  a_signal_span: assert property (
    sig_q <= SIG_W'(SPAN))
    else $error("signal above one supply span");
endmodule
`default_nettype wire

/* src/hsd_pkg.sv */
/*
  hsd_pkg: shared constants of the hall switch signal path.
  register indices, field positions, widths, reset values and the cut-off tables.
  assumes nothing of its surroundings.
*/
package hsd_pkg;

  // register indices on the command port
  localparam logic [3:0] IDX_RANGE_CUTOFF = 4'h0;
  localparam logic [3:0] IDX_LIN_TC = 4'h1;
  localparam logic [3:0] IDX_QUAD_TC = 4'h2;
  localparam logic [3:0] IDX_GAIN = 4'h3;
  localparam logic [3:0] IDX_ZERO_OFS = 4'h4;
  localparam logic [3:0] IDX_LOW_THR = 4'h5;
  localparam logic [3:0] IDX_HIGH_THR = 4'h6;
  localparam logic [3:0] IDX_FREEZE = 4'h7;
  localparam logic [3:0] IDX_TRIM = 4'h8;
  localparam logic [3:0] IDX_READOUT = 4'h9;

  // field positions of range_and_cutoff_select
  localparam int RANGE_LSB = 0;
  localparam int CUTOFF_LSB = 3;
  localparam int SEL_W = 3;
  localparam int MODE_W = 6;

  // widths
  localparam int SAMPLE_W = 14;
  localparam int TC_W = 8;
  localparam int GAIN_W = 14;
  localparam int OFS_W = 11;
  localparam int LOW_W = 10;
  localparam int HIGH_W = 11;
  localparam int SIG_W = 12;
  localparam int DATA_W = 16;

  // signal scale: one supply span is 2048 threshold steps
  localparam int GAIN_FRAC = 11;
  localparam logic signed [39:0] SPAN = 40'sh00_0000_0800;
  localparam int TEMP_FRAC = 16;
  localparam int LIN_TC_SCALE = 4;

  // reset values
  localparam logic [5:0] MODE_RST = 6'h12;
  localparam logic [7:0] TC_RST = 8'h00;
  localparam logic [13:0] GAIN_RST = 14'h0800;
  localparam logic [10:0] OFS_RST = 11'h000;
  localparam logic [9:0] LOW_RST = 10'h200;
  localparam logic [10:0] HIGH_RST = 11'h600;

  // filter cut-off codes
  localparam logic [2:0] CUT_80HZ = 3'h0;
  localparam logic [2:0] CUT_160HZ = 3'h1;
  localparam logic [2:0] CUT_500HZ = 3'h2;
  localparam logic [2:0] CUT_1KHZ = 3'h3;
  localparam logic [2:0] CUT_2KHZ = 3'h4;
  localparam int FILT_FRAC = 6;

  // filtered sample limits per cut-off
  localparam logic signed [13:0] LIM_80_MIN = -14'sd3968;
  localparam logic signed [13:0] LIM_80_MAX = 14'sd3967;
  localparam logic signed [13:0] LIM_160_MIN = -14'sd1985;
  localparam logic signed [13:0] LIM_160_MAX = 14'sd1985;
  localparam logic signed [13:0] LIM_500_MIN = -14'sd5292;
  localparam logic signed [13:0] LIM_500_MAX = 14'sd5290;
  localparam logic signed [13:0] LIM_1K_MIN = -14'sd2646;
  localparam logic signed [13:0] LIM_1K_MAX = 14'sd2645;
  localparam logic signed [13:0] LIM_2K_MIN = -14'sd1512;
  localparam logic signed [13:0] LIM_2K_MAX = 14'sd1511;

  typedef struct packed {
    logic [4:0] shift;
    logic signed [13:0] lo;
    logic signed [13:0] hi;
  } hsd_cut_t;

  // decoding of the cut-off field, used by the filter and its limit check
  function automatic hsd_cut_t hsd_cut_decode(input logic [2:0] code);
    hsd_cut_t c;
    c = '{shift: 5'd1, lo: LIM_2K_MIN, hi: LIM_2K_MAX};
    unique case (code)
      CUT_80HZ: c = '{shift: 5'd6, lo: LIM_80_MIN, hi: LIM_80_MAX};
      CUT_160HZ: c = '{shift: 5'd5, lo: LIM_160_MIN, hi: LIM_160_MAX};
      CUT_500HZ: c = '{shift: 5'd3, lo: LIM_500_MIN, hi: LIM_500_MAX};
      CUT_1KHZ: c = '{shift: 5'd2, lo: LIM_1K_MIN, hi: LIM_1K_MAX};
      default: c = '{shift: 5'd1, lo: LIM_2K_MIN, hi: LIM_2K_MAX};
    endcase
    return c;
  endfunction

endpackage

/* src/hsd_lowpass.sv */
/*
  hsd_lowpass: first order digital low-pass on the converter sample, limited per cut-off.
  assumes one sample strobe per converter result, synchronous to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hsd_lowpass
  import hsd_pkg::*;
#(
  parameter int W = SAMPLE_W
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // sample in
  input wire logic i_sample_valid,
  input wire logic signed [W-1:0] i_sample,
  input wire logic [2:0] i_cutoff,
  // filtered out
  output logic signed [W-1:0] o_filtered
);
  localparam int AW = W + FILT_FRAC + 2;
  initial if (W != SAMPLE_W) $error("hsd_lowpass: W must equal SAMPLE_W");

  logic signed [AW-1:0] acc_q, acc_d;
  logic signed [W-1:0] out_q, out_d;
  logic signed [AW-1:0] step;
  logic signed [AW-1:0] y;
  hsd_cut_t cut;

  always_comb begin
    cut = hsd_cut_decode(i_cutoff);
    step = (AW'(i_sample) <<< FILT_FRAC) - acc_q;
    acc_d = acc_q;
    if (i_sample_valid) begin
      acc_d = acc_q + (step >>> cut.shift);
    end
    y = acc_d >>> FILT_FRAC;
    // limit per cut-off
    if (y > AW'(cut.hi)) begin
      out_d = cut.hi;
    end else if (y < AW'(cut.lo)) begin
      out_d = cut.lo;
    end else begin
      out_d = W'(y);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      acc_q <= '0;
      out_q <= '0;
    end else begin
      acc_q <= acc_d;
      out_q <= out_d;
    end
  end

  assign o_filtered = out_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_filt_within_limit: assert property (
    ##1 (o_filtered <= hsd_cut_decode($past(i_cutoff)).hi && o_filtered >= hsd_cut_decode($past(i_cutoff)).lo))
    else $error("filtered sample outside cut-off limit");
  a_filt_idle_hold: assert property (
    !i_sample_valid && $stable(i_cutoff) ##1 !i_sample_valid |-> $stable(o_filtered))
    else $error("filtered sample moved without a sample");
endmodule
`default_nettype wire

/* tb/hsd_prog_model.sv */
/*
  hsd_prog_model: programmer on the far side of the supply and output pins.
  assumes the bench clock and the core's command port, output pin and drive enable.
*/
`timescale 1ns/1ps
`default_nettype none
module hsd_prog_model
  import hsd_pkg::*;
(
  // clock and device pins
  input wire logic i_clock,
  input wire logic i_out,
  input wire logic i_out_oe,
  input wire logic i_rsp_valid,
  // towards the core
  output logic o_raised_supply,
  output logic o_out_pin,
  output logic o_cmd_valid,
  output logic o_cmd_write,
  output logic [3:0] o_cmd_index,
  output logic [DATA_W-1:0] o_cmd_wdata
);
  logic pin_q;
  // pin level: device drives while enabled, programmer otherwise
  assign o_out_pin = i_out_oe ? i_out : pin_q;
  initial begin
    pin_q = 1'b0;
    o_raised_supply = 1'b0;
    o_cmd_valid = 1'b0;
    o_cmd_write = 1'b0;
    o_cmd_index = 4'h0;
    o_cmd_wdata = 16'h0000;
  end
  task automatic supply(input logic up);
    @(negedge i_clock);
    o_raised_supply = up;
    repeat (3) @(negedge i_clock);
  endtask
  task automatic select_pulse();
    pin_q = 1'b1;
    repeat (2) @(negedge i_clock);
    pin_q = 1'b0;
    repeat (2) @(negedge i_clock);
  endtask
  task automatic cmd(input logic wr, input logic [3:0] idx, input logic [DATA_W-1:0] wd, output logic got);
    @(negedge i_clock);
    o_cmd_valid = 1'b1;
    o_cmd_write = wr;
    o_cmd_index = idx;
    o_cmd_wdata = wd;
    @(negedge i_clock);
    o_cmd_valid = 1'b0;
    o_cmd_wdata = ~wd;
    got = 1'b0;
    for (int k = 0; k < 3 && !got; k++) begin
      if (i_rsp_valid === 1'b1) got = 1'b1;
      else @(negedge i_clock);
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
  tb_top: self-checking bench of hsd_core with a programmer model.
  assumes a 20 MHz clock and inputs driven at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import hsd_pkg::*;
;
  logic i_clock, i_sys_rst, i_sample_valid, i_stored_freeze, got;
  logic signed [SAMPLE_W-1:0] i_sample;
  logic signed [TC_W-1:0] temp_delta;
  logic raised, pin, cmd_valid, cmd_write, o_out, o_out_oe, rsp_valid, selected;
  logic [3:0] cmd_index;
  logic [DATA_W-1:0] cmd_wdata, rsp_data;
  logic [SEL_W-1:0] field_range;
  int n_mismatch, tests_run;
  hsd_core #(.TRIM_VALUE(16'hA5C3), .IDX_W(4)) dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sample_valid(i_sample_valid), .i_sample(i_sample),
    .i_temp_delta(temp_delta), .o_field_range(field_range), .i_raised_supply(raised),
    .i_stored_freeze(i_stored_freeze), .i_out_pin(pin), .o_out(o_out), .o_out_oe(o_out_oe),
    .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_index(cmd_index), .i_cmd_wdata(cmd_wdata),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_selected(selected));
  hsd_prog_model prog (
    .i_clock(i_clock), .i_out(o_out), .i_out_oe(o_out_oe), .i_rsp_valid(rsp_valid),
    .o_raised_supply(raised), .o_out_pin(pin), .o_cmd_valid(cmd_valid), .o_cmd_write(cmd_write),
    .o_cmd_index(cmd_index), .o_cmd_wdata(cmd_wdata));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [DATA_W-1:0] d);
    prog.cmd(1'b1, idx, d, got);
  endtask
  task automatic rd(input logic [3:0] idx, input logic [DATA_W-1:0] exp);
    prog.cmd(1'b0, idx, 16'h0000, got);
    check({15'h0000, got}, 16'h0001, "read answer");
    check(rsp_data, exp, "read data");
  endtask
  task automatic prog_on();
    prog.supply(1'b1);
    prog.select_pulse();
  endtask
  task automatic feed(input logic signed [SAMPLE_W-1:0] x);
    repeat (30) begin
      @(negedge i_clock);
      i_sample_valid = 1'b1;
      i_sample = x;
      @(negedge i_clock);
      i_sample_valid = 1'b0;
    end
    repeat (4) @(negedge i_clock);
  endtask
  task automatic t_select();
    check({15'h0000, o_out}, 16'h0001, "out at reset");
    check({13'h0000, field_range}, 16'h0002, "range at reset");
    prog.supply(1'b1);
    check({15'h0000, o_out_oe}, 16'h0000, "drive during programming");
    prog.cmd(1'b0, IDX_RANGE_CUTOFF, 16'h0000, got);
    check({15'h0000, got}, 16'h0000, "unselected read");
    prog.select_pulse();
    check({15'h0000, selected}, 16'h0001, "selected");
    $display("test select done");
  endtask
  task automatic t_regs();
    rd(IDX_RANGE_CUTOFF, 16'h0012);
    wr(IDX_RANGE_CUTOFF, 16'h0027);
    rd(IDX_RANGE_CUTOFF, 16'h0027);
    check({13'h0000, field_range}, 16'h0007, "range code");
    wr(IDX_LIN_TC, 16'h0005);
    rd(IDX_LIN_TC, 16'h0005);
    wr(IDX_QUAD_TC, 16'h0003);
    rd(IDX_QUAD_TC, 16'h0003);
    wr(IDX_TRIM, 16'hFFFF);
    rd(IDX_TRIM, 16'hA5C3);
    rd(4'hA, 16'h0000);
    wr(IDX_ZERO_OFS, 16'hFF00);
    rd(IDX_ZERO_OFS, 16'hFF00);
    wr(IDX_ZERO_OFS, 16'h0000);
    wr(IDX_GAIN, 16'h1000);
    rd(IDX_GAIN, 16'h1000);
    rd(IDX_LOW_THR, 16'h0200);
    rd(IDX_HIGH_THR, 16'h0600);
    $display("test registers done");
  endtask
  task automatic t_switch();
    prog.supply(1'b0);
    feed(-14'sd1000);
    check({15'h0000, o_out}, 16'h0001, "below low");
    feed(14'sd1000);
    check({15'h0000, o_out}, 16'h0000, "above high");
    feed(14'sd400);
    check({15'h0000, o_out}, 16'h0000, "hold low");
    feed(-14'sd1000);
    feed(14'sd400);
    check({15'h0000, o_out}, 16'h0001, "hold high");
    feed(14'sd500);
    check({15'h0000, o_out}, 16'h0001, "hold high cold");
    @(negedge i_clock);
    temp_delta = 8'sh7F;
    repeat (4) @(negedge i_clock);
    check({15'h0000, o_out}, 16'h0000, "temperature raised gain");
    temp_delta = 8'sh00;
    feed(-14'sd400);
    prog_on();
    prog.cmd(1'b0, IDX_READOUT, 16'h0000, got);
    check({15'h0000, got}, 16'h0001, "readout answer");
    tests_run++;
    if ((($signed(rsp_data) <= -16'sh018F) && ($signed(rsp_data) >= -16'sh0191)) !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t readout %h", $time, rsp_data);
    end
    $display("test switching done");
  endtask
  task automatic t_clamp();
    wr(IDX_GAIN, 16'h1800);
    wr(IDX_ZERO_OFS, 16'hFF00);
    prog.supply(1'b0);
    feed(14'sd1000);
    check({15'h0000, o_out}, 16'h0001, "clamped at high");
    prog_on();
    wr(IDX_HIGH_THR, 16'h05FF);
    feed(14'sd1000);
    check({15'h0000, o_out}, 16'h0001, "no switching raised");
    prog.supply(1'b0);
    feed(14'sd1000);
    check({15'h0000, o_out}, 16'h0000, "above clamp");
    $display("test clamp done");
  endtask
  task automatic t_freeze();
    prog_on();
    wr(IDX_FREEZE, 16'h0001);
    prog.cmd(1'b0, IDX_RANGE_CUTOFF, 16'h0000, got);
    check({15'h0000, got}, 16'h0000, "frozen read");
    wr(IDX_RANGE_CUTOFF, 16'h0000);
    check({13'h0000, field_range}, 16'h0007, "frozen write");
    check({15'h0000, o_out_oe}, 16'h0001, "frozen drive");
    feed(-14'sd1000);
    check({15'h0000, o_out}, 16'h0001, "frozen switching");
    prog.supply(1'b0);
    prog_on();
    check({15'h0000, selected}, 16'h0000, "frozen select");
    $display("test freeze done");
  endtask
  task automatic t_stored();
    @(negedge i_clock);
    i_stored_freeze = 1'b1;
    i_sys_rst = 1'b1;
    repeat (5) @(negedge i_clock);
    i_sys_rst = 1'b0;
    @(negedge i_clock);
    check({15'h0000, o_out}, 16'h0001, "out after reset");
    check({13'h0000, field_range}, 16'h0002, "range after reset");
    prog.supply(1'b1);
    check({15'h0000, o_out_oe}, 16'h0001, "stored freeze drive");
    prog.select_pulse();
    check({15'h0000, selected}, 16'h0000, "stored freeze select");
    $display("test stored freeze done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_mismatch++;
    results();
  end
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    i_sys_rst = 1'b1;
    i_sample_valid = 1'b0;
    i_sample = 14'sh0000;
    i_stored_freeze = 1'b0;
    temp_delta = 8'sh00;
    repeat (5) @(negedge i_clock);
    i_sys_rst = 1'b0;
    @(negedge i_clock);
    t_select();
    t_regs();
    t_switch();
    t_clamp();
    t_freeze();
    t_stored();
    results();
  end
endmodule
`default_nettype wire
